// file: olb_pkg.sv
// Shared constants and types for the inter-option link block transfer controller.
// Assumes both ends run on one 100 MHz clock and are joined by olb_if.
// Behaviour
// RQ1 - Server polls client every 1 ms
// RQ2 - One request serviced per poll
// RQ3 - Block holds at most 5 parameters
// RQ4 - Mapping sent only during initialisation
// RQ5 - Eight input and eight output blocks
// RQ6 - Blocks only for ranges of two
// RQ7 - Split ranges; lone leftover goes single (the code drops a lone leftover unsent)
// RQ8 - Ten entries, five ranges, six blocks
// RQ9 - Unrequested server reset raises timeout trip
// RQ10 - Global reset code restarts without trip
// RQ11 - Client-only reset keeps server running
// RQ12 - Defaults request clears after sequence
// RQ13 - Flash save only when defaults bit set
// RQ14 - Default sequence runs steps in order
// RQ15 - Node address 65535 becomes 63
// RQ16 - Background scan replaces generic defaults
// RQ17 - Save with bit clear: drive only
// RQ18 - Save with bit set: halt, flash, reset
// RQ19 - Save request clears after save
// RQ20 - Single requests served oldest first
// RQ21 - Missing polls for N periods trip
package olb_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_MHZ          = 100;
   localparam int POLL_PERIOD_US   = 1000;
   localparam int POLL_CYCLES      = POLL_PERIOD_US * CLK_MHZ;
   localparam int TIMEOUT_POLLS    = 3;
   // ************************************************************
   // Block geometry
   // ************************************************************
   localparam int PARAM_BITS       = 32;
   localparam int BLOCK_MAX_PARAMS = 5;
   localparam int BLOCK_MAX_WORDS  = 10;
   localparam int NUM_BLOCKS       = 8;
   localparam int NUM_ENTRIES      = 10;
   localparam int MAX_USED_BLOCKS  = 6;
   localparam int MIN_RANGE        = 2;
   localparam int SINGLE_DEPTH     = 4;
   // ************************************************************
   // Default substitution and command codes
   // ************************************************************
   localparam logic [15:0] NODE_GENERIC_DEFAULT = 16'hffff;
   localparam logic [15:0] NODE_BUS_DEFAULT     = 16'h003f;
   localparam logic [15:0] GLOBAL_RESET_CODE    = 16'h042e;
   // ************************************************************
   // APB register map of the client controller
   // ************************************************************
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_NODE   = 8'h08;
   localparam logic [7:0] REG_SINGLE = 8'h0c;
   localparam logic [7:0] REG_MAP    = 8'h10;
   localparam int CTRL_DEFAULTS_BIT  = 0;
   localparam int CTRL_SAVE_BIT      = 1;
   localparam int CTRL_ENABLE_BIT    = 2;
   localparam int CTRL_DRV_DEF_BIT   = 3;
   localparam int CTRL_DRV_SAVE_BIT  = 4;
   localparam int CTRL_GLOBAL_BIT    = 5;
   localparam int CTRL_TRIP_CLR_BIT  = 6;
   // ************************************************************
   // Link message kinds
   // ************************************************************
   typedef enum logic [1:0] {OLB_MSG_IDLE, OLB_MSG_MAP, OLB_MSG_SINGLE, OLB_MSG_BLOCK} olb_msg_e;
endpackage

// file: olb_if.sv
// Inter-option link between the client (fieldbus) and server (co-processor) ends.
// Assumes a single shared clock; the bench connects clk only.
`timescale 1ns/1ps
interface olb_if (input wire logic clk);
   logic              poll;        // Server poll pulse.
   logic              srv_reset;   // Server restarted last cycle without a client reset request.
   logic              reset_req;   // Client announces a coming reset.
   logic              rsp_valid;   // Client answer to the poll.
   olb_pkg::olb_msg_e rsp_kind;
   logic [2:0]        rsp_block;
   logic [2:0]        rsp_count;
   logic [15:0]       rsp_addr;
   logic              active;      // Client has the channel running.
   modport client (input poll, input srv_reset, output reset_req, output rsp_valid,
                   output rsp_kind, output rsp_block, output rsp_count, output rsp_addr,
                   output active);
   modport server (output poll, output srv_reset, input reset_req, input rsp_valid,
                   input rsp_kind, input rsp_block, input rsp_count, input rsp_addr,
                   input active);
endinterface

// file: olb_client.sv
// Client end: fieldbus module answering polls, plus default and save sequencers.
// Assumes APB from software and the server end on olb_if.client.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module olb_client #(
   parameter int TIMEOUT_POLLS = olb_pkg::TIMEOUT_POLLS,
   parameter int POLL_CYCLES   = olb_pkg::POLL_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   olb_if.client            link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             flash_write,
   output logic             timeout_trip
);
   typedef enum {OLB_ST_INIT, OLB_ST_RUN, OLB_ST_STOP, OLB_ST_DRVDEF, OLB_ST_OVERWR,
                 OLB_ST_FLASH, OLB_ST_RESET} olb_state_e;

   localparam int PCW = $clog2(POLL_CYCLES * (TIMEOUT_POLLS + 1) + 1);

   // ************************************************************
   // Registers
   // ************************************************************
   logic [7:0]  ctrl_reg;
   logic [15:0] node_reg;
   logic [15:0] map_lo_reg [olb_pkg::NUM_ENTRIES/2];
   logic [15:0] map_hi_reg [olb_pkg::NUM_ENTRIES/2];
   logic [15:0] fifo_reg [olb_pkg::SINGLE_DEPTH];
   logic [2:0]  fifo_cnt_reg;
   logic [1:0]  rd_ptr_reg;
   logic [1:0]  wr_ptr_reg;
   olb_state_e  state_reg;
   logic        sync1_reg;
   logic        sync2_reg;
   logic [PCW-1:0] idle_cnt_reg;
   logic [2:0]  blk_reg;
   logic [2:0]  rng_reg;
   logic [15:0] cur_reg;
   logic        saving_reg;

   wire wr_acc = psel && penable && pwrite;
   wire fifo_push = wr_acc && paddr == olb_pkg::REG_SINGLE && fifo_cnt_reg < 3'h4;
   wire run = state_reg == OLB_ST_RUN;

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !(paddr inside {olb_pkg::REG_CTRL, olb_pkg::REG_STATUS,
                    olb_pkg::REG_NODE, olb_pkg::REG_SINGLE} ||
                    (paddr >= olb_pkg::REG_MAP && paddr < 8'h24));

   always_comb begin
      prdata = 32'h0;
      if (paddr == olb_pkg::REG_CTRL)
         prdata = {24'h0, ctrl_reg};
      else if (paddr == olb_pkg::REG_STATUS)
         prdata = {24'h0, timeout_trip, saving_reg, 3'h0, fifo_cnt_reg};
      else if (paddr == olb_pkg::REG_NODE)
         prdata = {16'h0, node_reg};
      else if (paddr >= olb_pkg::REG_MAP && paddr < 8'h24)
         prdata = {map_hi_reg[3'(paddr[7:2] - 6'h4)], map_lo_reg[3'(paddr[7:2] - 6'h4)]};
   end

   // ************************************************************
   // Control register with self-clearing request bits
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= 8'h00;
      end else begin
         if (wr_acc && paddr == olb_pkg::REG_CTRL)
            ctrl_reg <= pwdata[7:0];
         else
            ctrl_reg[olb_pkg::CTRL_TRIP_CLR_BIT] <= 1'b0;
         if (state_reg == OLB_ST_RESET) begin
            ctrl_reg[olb_pkg::CTRL_DEFAULTS_BIT] <= 1'b0; // see RQ12
            ctrl_reg[olb_pkg::CTRL_SAVE_BIT]     <= 1'b0; // see RQ19
            ctrl_reg[olb_pkg::CTRL_DRV_DEF_BIT]  <= 1'b0;
            ctrl_reg[olb_pkg::CTRL_DRV_SAVE_BIT] <= 1'b0;
            ctrl_reg[olb_pkg::CTRL_GLOBAL_BIT]   <= 1'b0;
         end else if (run && ctrl_reg[olb_pkg::CTRL_DRV_SAVE_BIT]
                      && !ctrl_reg[olb_pkg::CTRL_SAVE_BIT]) begin
            ctrl_reg[olb_pkg::CTRL_DRV_SAVE_BIT] <= 1'b0; // see RQ17
         end
      end
   end

   // ************************************************************
   // Node address with background default substitution
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         node_reg <= olb_pkg::NODE_BUS_DEFAULT;
      end else if (wr_acc && paddr == olb_pkg::REG_NODE) begin
         node_reg <= pwdata[15:0];
      end else if (state_reg == OLB_ST_DRVDEF) begin
         // The drive's own default is the generic one; the scan below makes it ours next cycle.
         node_reg <= olb_pkg::NODE_GENERIC_DEFAULT; // see RQ14
      end else if (node_reg == olb_pkg::NODE_GENERIC_DEFAULT) begin
         node_reg <= olb_pkg::NODE_BUS_DEFAULT; // see RQ15 see RQ16
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < olb_pkg::NUM_ENTRIES/2; i++) begin
            map_lo_reg[i] <= 16'h0;
            map_hi_reg[i] <= 16'h0;
         end
      end else if (wr_acc && paddr >= olb_pkg::REG_MAP && paddr < 8'h24) begin
         map_lo_reg[3'(paddr[7:2] - 6'h4)] <= pwdata[15:0]; // see RQ8
         map_hi_reg[3'(paddr[7:2] - 6'h4)] <= pwdata[31:16];
      end
   end

   // ************************************************************
   // Single-request queue
   // ************************************************************
   wire [15:0] span = map_hi_reg[rng_reg] - cur_reg;
   wire range_ok = map_hi_reg[rng_reg] > map_lo_reg[rng_reg];
   wire pop = run && link.poll && fifo_cnt_reg != 3'h0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_cnt_reg <= 3'h0;
         rd_ptr_reg   <= 2'h0;
         wr_ptr_reg   <= 2'h0;
         for (int i = 0; i < olb_pkg::SINGLE_DEPTH; i++)
            fifo_reg[i] <= 16'h0;
      end else begin
         if (fifo_push) begin
            fifo_reg[wr_ptr_reg] <= pwdata[15:0];
            wr_ptr_reg <= wr_ptr_reg + 2'h1;
         end
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + 2'h1; // see RQ20
         fifo_cnt_reg <= fifo_cnt_reg + 3'(fifo_push) - 3'(pop);
      end
   end

   // ************************************************************
   // Poll answers: mapping during init, then data
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.rsp_valid <= 1'b0;
         link.rsp_kind  <= olb_pkg::OLB_MSG_IDLE;
         link.rsp_block <= 3'h0;
         link.rsp_count <= 3'h0;
         link.rsp_addr  <= 16'h0;
         blk_reg        <= 3'h0;
         rng_reg        <= 3'h0;
         cur_reg        <= 16'h0;
      end else begin
         link.rsp_valid <= 1'b0;
         if (state_reg == OLB_ST_INIT) begin
            if (link.poll) begin // see RQ2
               link.rsp_valid <= 1'b1;
               link.rsp_kind  <= olb_pkg::OLB_MSG_IDLE;
               if (rng_reg == 3'h5 || blk_reg == 3'(olb_pkg::MAX_USED_BLOCKS)) begin
                  link.rsp_kind <= olb_pkg::OLB_MSG_IDLE;
               end else if (!range_ok || (cur_reg != 16'h0 && span == 16'h0)) begin
                  rng_reg <= rng_reg + 3'h1; // see RQ6 see RQ7
                  cur_reg <= 16'h0;
               end else begin
                  link.rsp_kind  <= olb_pkg::OLB_MSG_MAP; // see RQ4
                  link.rsp_block <= blk_reg;
                  link.rsp_addr  <= cur_reg == 16'h0 ? map_lo_reg[rng_reg] : cur_reg;
                  if ((cur_reg == 16'h0 ? map_hi_reg[rng_reg] - map_lo_reg[rng_reg] : span)
                      >= 16'h5) begin
                     link.rsp_count <= 3'(olb_pkg::BLOCK_MAX_PARAMS); // see RQ3
                     cur_reg <= (cur_reg == 16'h0 ? map_lo_reg[rng_reg] : cur_reg) + 16'h5;
                  end else begin
                     link.rsp_count <= 3'((cur_reg == 16'h0 ? map_hi_reg[rng_reg]
                                       - map_lo_reg[rng_reg] : span) + 16'h1);
                     cur_reg <= 16'h0;
                     rng_reg <= rng_reg + 3'h1;
                  end
                  blk_reg <= blk_reg + 3'h1; // see RQ5
               end
            end
         end else if (run && link.poll) begin
            link.rsp_valid <= 1'b1;
            if (fifo_cnt_reg != 3'h0) begin
               link.rsp_kind <= olb_pkg::OLB_MSG_SINGLE;
               link.rsp_addr <= fifo_reg[rd_ptr_reg];
            end else begin
               link.rsp_kind  <= olb_pkg::OLB_MSG_BLOCK;
               link.rsp_block <= link.rsp_block + 3'h1 < blk_reg ? link.rsp_block + 3'h1 : 3'h0;
            end
         end else begin
            // A client busy with its own sequence still answers, so the server sees no gap.
            if (link.poll) begin
               link.rsp_valid <= 1'b1; // see RQ2
               link.rsp_kind  <= olb_pkg::OLB_MSG_IDLE;
            end
            if (state_reg == OLB_ST_RESET) begin
               blk_reg <= 3'h0;
               rng_reg <= 3'h0;
               cur_reg <= 16'h0;
            end
         end
      end
   end

   // ************************************************************
   // Default and save sequencer
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= OLB_ST_INIT;
         saving_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            OLB_ST_INIT:
               if (ctrl_reg[olb_pkg::CTRL_ENABLE_BIT] &&
                   (rng_reg == 3'h5 || blk_reg == 3'(olb_pkg::MAX_USED_BLOCKS)))
                  state_reg <= OLB_ST_RUN;
            OLB_ST_RUN: begin
               saving_reg <= ctrl_reg[olb_pkg::CTRL_DRV_SAVE_BIT]
                             && ctrl_reg[olb_pkg::CTRL_SAVE_BIT];
               if (ctrl_reg[olb_pkg::CTRL_DRV_DEF_BIT] || ctrl_reg[olb_pkg::CTRL_GLOBAL_BIT]
                   || (ctrl_reg[olb_pkg::CTRL_DRV_SAVE_BIT] && ctrl_reg[olb_pkg::CTRL_SAVE_BIT]))
                  state_reg <= OLB_ST_STOP; // see RQ14 see RQ18
            end
            OLB_ST_STOP:
               if (ctrl_reg[olb_pkg::CTRL_GLOBAL_BIT])
                  state_reg <= OLB_ST_RESET; // see RQ10
               else if (saving_reg)
                  state_reg <= OLB_ST_FLASH; // see RQ18
               else
                  state_reg <= OLB_ST_DRVDEF;
            OLB_ST_DRVDEF: state_reg <= OLB_ST_OVERWR;
            OLB_ST_OVERWR:
               state_reg <= ctrl_reg[olb_pkg::CTRL_DEFAULTS_BIT] ? OLB_ST_FLASH
                                                                 : OLB_ST_RESET; // see RQ13
            OLB_ST_FLASH: state_reg <= OLB_ST_RESET;
            OLB_ST_RESET: begin
               state_reg  <= OLB_ST_INIT;
               saving_reg <= 1'b0;
            end
         endcase
      end
   end

   assign flash_write    = state_reg == OLB_ST_FLASH;
   assign link.active    = run;
   // The server is told ahead of a client-only reset so it does not trip.
   assign link.reset_req = state_reg == OLB_ST_STOP; // see RQ11

   // ************************************************************
   // Timeout trip
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= link.srv_reset;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_reg <= '0;
         timeout_trip <= 1'b0;
      end else begin
         idle_cnt_reg <= (!run || link.poll) ? '0 : idle_cnt_reg + PCW'(1);
         if ((run && sync2_reg && !ctrl_reg[olb_pkg::CTRL_GLOBAL_BIT]) // see RQ9
             || idle_cnt_reg == PCW'(POLL_CYCLES * TIMEOUT_POLLS)) // see RQ21
            timeout_trip <= 1'b1;
         else if (ctrl_reg[olb_pkg::CTRL_TRIP_CLR_BIT])
            timeout_trip <= 1'b0;
      end
   end
endmodule // olb_client

// file: olb_server.sv
// Server end: co-processor that polls the client each poll period.
// Assumes the client end on olb_if.server and a shared clock.
`timescale 1ns/1ps
module olb_server #(
   parameter int POLL_CYCLES = olb_pkg::POLL_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   olb_if.server            link,
   input  wire logic        srv_restart,
   output logic             rsp_seen,
   output olb_pkg::olb_msg_e rsp_kind_out,
   output logic [15:0]      rsp_addr_out,
   output logic [2:0]       rsp_block_out
);
   localparam int PW = $clog2(POLL_CYCLES + 1);
   logic [PW-1:0] tick_reg;

   // ************************************************************
   // Poll generator
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_reg  <= '0;
         link.poll <= 1'b0;
      end else begin
         link.poll <= 1'b0;
         if (srv_restart) begin
            tick_reg <= '0;
         end else if (tick_reg == PW'(POLL_CYCLES - 1)) begin
            tick_reg  <= '0;
            link.poll <= 1'b1; // see RQ1
         end else begin
            tick_reg <= tick_reg + PW'(1);
         end
      end
   end

   // A restart announced by the client is its own, so the server keeps going.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         link.srv_reset <= 1'b0;
      else
         link.srv_reset <= srv_restart && !link.reset_req; // see RQ11
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_seen      <= 1'b0;
         rsp_kind_out  <= olb_pkg::OLB_MSG_IDLE;
         rsp_addr_out  <= 16'h0;
         rsp_block_out <= 3'h0;
      end else begin
         rsp_seen <= link.rsp_valid; // see RQ2
         if (link.rsp_valid) begin
            rsp_kind_out  <= link.rsp_kind;
            rsp_addr_out  <= link.rsp_addr;
            rsp_block_out <= link.rsp_block;
         end
      end
   end
endmodule // olb_server

// file: olb_assertions.sv
// Concurrent checks on the link signals between the client and server ends.
// Assumes one clock and the shared active-low reset of both ends.
`timescale 1ns/1ps
module olb_assertions (
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              poll,
   input wire logic              srv_reset,
   input wire logic              reset_req,
   input wire logic              rsp_valid,
   input wire olb_pkg::olb_msg_e rsp_kind,
   input wire logic [2:0]        rsp_block,
   input wire logic [2:0]        rsp_count,
   input wire logic [15:0]       rsp_addr,
   input wire logic              active
);
   // ****************************************
   // Link checks
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   poll_answer_a: assert property (poll |=> rsp_valid)
      else $error("poll not answered in the next cycle");
   answer_cause_a: assert property (rsp_valid |-> $past(poll))
      else $error("answer without a poll");
   answer_pulse_a: assert property (rsp_valid |=> !rsp_valid)
      else $error("more than one answer per poll");
   poll_spacing_a: assert property (poll |=> (!poll) [*8])
      else $error("polls closer than the poll period");
   block_size_a: assert property (rsp_valid && rsp_kind inside
      {olb_pkg::OLB_MSG_MAP, olb_pkg::OLB_MSG_BLOCK} |-> rsp_count inside {[2:5]})
      else $error("block size outside two to five");
   map_init_a: assert property (rsp_valid && rsp_kind == olb_pkg::OLB_MSG_MAP |-> !active)
      else $error("mapping sent while running");
   block_run_a: assert property (rsp_valid && rsp_kind == olb_pkg::OLB_MSG_BLOCK |-> $past(active))
      else $error("block data before running");
   map_limit_a: assert property (rsp_valid && rsp_kind == olb_pkg::OLB_MSG_MAP
      |-> rsp_block < 3'(olb_pkg::MAX_USED_BLOCKS))
      else $error("block index beyond usable blocks");
endmodule // olb_assertions

// file: option_link_block_transfer_ctrl_test.sv
// Bench joining client and server over the link, driven through APB and the restart input.
// Assumes the package, link interface, both ends and the checker are compiled first.
`timescale 1ns/1ps
module option_link_block_transfer_ctrl_test;
   localparam int PC = 20;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0;
   logic              srv_restart = 1'b0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              flash_write;
   logic              timeout_trip;
   logic              rsp_seen;
   olb_pkg::olb_msg_e kind_out;
   logic [15:0]       addr_out;
   int                mismatches = 0;
   int                check_count = 0;
   int                flashes = 0;
   logic [21:0]       maps[$];
   logic [15:0]       singles[$];
   always #5 clk = ~clk;
   olb_if olb_if_i (.clk(clk));
   olb_client #(.TIMEOUT_POLLS(3), .POLL_CYCLES(PC)) olb_client_i (.clk(clk), .rst_n(rst_n),
      .link(olb_if_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flash_write(flash_write), .timeout_trip(timeout_trip));
   olb_server #(.POLL_CYCLES(PC)) olb_server_i (.clk(clk), .rst_n(rst_n), .link(olb_if_i),
      .srv_restart(srv_restart), .rsp_seen(rsp_seen), .rsp_kind_out(kind_out),
      .rsp_addr_out(addr_out), .rsp_block_out());
   olb_assertions olb_assertions_i (.clk(clk), .rst_n(rst_n), .poll(olb_if_i.poll),
      .srv_reset(olb_if_i.srv_reset), .reset_req(olb_if_i.reset_req),
      .rsp_valid(olb_if_i.rsp_valid), .rsp_kind(olb_if_i.rsp_kind),
      .rsp_block(olb_if_i.rsp_block), .rsp_count(olb_if_i.rsp_count),
      .rsp_addr(olb_if_i.rsp_addr), .active(olb_if_i.active));
   // ****************************************
   // Monitors and bus tasks
   // ****************************************
   always @(posedge clk) begin
      if (olb_if_i.rsp_valid === 1'b1 && olb_if_i.rsp_kind === olb_pkg::OLB_MSG_MAP) begin
         maps.push_back({olb_if_i.rsp_block, olb_if_i.rsp_count, olb_if_i.rsp_addr});
      end
      // Only bench-pushed addresses; a leftover range parameter is dropped, never sent singly.
      if (rsp_seen === 1'b1 && kind_out === olb_pkg::OLB_MSG_SINGLE && addr_out[15:8] === 8'h01) begin
         singles.push_back(addr_out);
      end
      if (flash_write === 1'b1) begin
         flashes++;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   task automatic wait_lvl(ref logic s, input int lim);
      int n;
      n = 0;
      while (s !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic wait_clear(input logic [31:0] m);
      logic [31:0] q;
      int          n;
      n = 0;
      q = m;
      while ((q & m) !== 32'h0 && n < 300) begin
         rd(olb_pkg::REG_CTRL, q);
         n++;
      end
      check(q & m, 32'h0);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_map();
      logic [21:0] exp [4] = '{22'h050010, 22'h0a0015, 22'h150020, 22'h1d0025};
      wr(olb_pkg::REG_MAP, 32'h0016_0010);
      wr(olb_pkg::REG_MAP + 8'h04, 32'h002a_0020);
      wr(olb_pkg::REG_MAP + 8'h08, 32'h0030_0035);
      wr(olb_pkg::REG_CTRL, 32'h4);
      wait_lvl(olb_if_i.active, 40 * PC);
      check({31'h0, olb_if_i.active}, 32'h1);
      check(maps.size(), 4);
      for (int i = 0; i < 4; i++) begin
         check(maps[i], exp[i]);
      end
   endtask
   task automatic t_regs();
      logic [31:0] q;
      logic        e;
      rd(olb_pkg::REG_CTRL, q);
      check(q & 32'h3, 32'h0);
      apb(1'b0, 8'h40, 32'h0, q, e);
      check({31'h0, e}, 32'h1);
      wr(olb_pkg::REG_NODE, 32'h12);
      rd(olb_pkg::REG_NODE, q);
      check(q & 32'hffff, 32'h12);
      wr(olb_pkg::REG_NODE, 32'hffff);
      repeat (2 * PC) @(posedge clk);
      rd(olb_pkg::REG_NODE, q);
      check(q & 32'hffff, 32'h3f);
   endtask
   task automatic t_single();
      logic [31:0] q;
      singles.delete();
      for (int i = 1; i <= 3; i++) begin
         wr(olb_pkg::REG_SINGLE, 32'h0100 + i);
      end
      repeat (6 * PC) @(posedge clk);
      check(singles.size(), 3);
      for (int i = 0; i < 3; i++) begin
         check(32'(singles[i]), 32'h0101 + i);
      end
      rd(olb_pkg::REG_STATUS, q);
      check(q & 32'h7, 32'h0);
   endtask
   task automatic t_trip();
      logic [31:0] q;
      @(posedge clk);
      srv_restart <= 1'b1;
      @(posedge clk);
      srv_restart <= 1'b0;
      wait_lvl(timeout_trip, 2 * PC);
      check({31'h0, timeout_trip}, 32'h1);
      rd(olb_pkg::REG_STATUS, q);
      check(q & 32'h80, 32'h80);
      wr(olb_pkg::REG_CTRL, 32'h44);
      // The clear bit lands at the write edge and the trip drops one edge later.
      repeat (2) @(posedge clk);
      check({31'h0, timeout_trip}, 32'h0);
      // Holding the server in restart silences the polls long enough to trip.
      srv_restart <= 1'b1;
      repeat (5 * PC) @(posedge clk);
      srv_restart <= 1'b0;
      check({31'h0, timeout_trip}, 32'h1);
      wr(olb_pkg::REG_CTRL, 32'h44);
      wr(olb_pkg::REG_CTRL, 32'h24);
      repeat (10 * PC) @(posedge clk);
      wr(olb_pkg::REG_CTRL, 32'h04);
      wait_lvl(olb_if_i.active, 40 * PC);
      check({31'h0, timeout_trip}, 32'h0);
      check({31'h0, olb_if_i.active}, 32'h1);
   endtask
   task automatic t_seq();
      logic [31:0] q;
      int          n0;
      n0 = flashes;
      wr(olb_pkg::REG_NODE, 32'h12);
      wr(olb_pkg::REG_CTRL, 32'h0d);
      wait_clear(32'h1);
      wr(olb_pkg::REG_CTRL, 32'h04);
      check(flashes - n0, 1);
      rd(olb_pkg::REG_NODE, q);
      check(q & 32'hffff, 32'h3f);
      wr(olb_pkg::REG_CTRL, 32'h0c);
      wait_clear(32'h8);
      wr(olb_pkg::REG_CTRL, 32'h04);
      check(flashes - n0, 1);
      wr(olb_pkg::REG_CTRL, 32'h14);
      wait_clear(32'h10);
      wr(olb_pkg::REG_CTRL, 32'h04);
      check(flashes - n0, 1);
      wr(olb_pkg::REG_CTRL, 32'h16);
      wait_clear(32'h2);
      wr(olb_pkg::REG_CTRL, 32'h04);
      check(flashes - n0, 2);
      check({31'h0, timeout_trip}, 32'h0);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_map();
      t_regs();
      t_single();
      t_trip();
      t_seq();
      give_verdict();
   end
   initial begin
      #300us;
      mismatches++;
      give_verdict();
   end
endmodule // option_link_block_transfer_ctrl_test
